// File: hw/smcg_pkg.sv
// smcg_pkg: register map, field layout and reset values of the clock gating block.
// assumes: one 40 MHz system clock, AXI4-Lite register access with 32-bit data.
package smcg_pkg;
    localparam logic [31:0] SMCG_SYSCTL_BASE   = 32'h400FE000;
    localparam logic [11:0] SMCG_OFS_RUN       = 12'h100;
    localparam logic [11:0] SMCG_OFS_SLEEP     = 12'h110;
    localparam logic [11:0] SMCG_OFS_DEEP      = 12'h120;
    localparam logic [11:0] SMCG_OFS_RUNCFG    = 12'h060;
    localparam logic [11:0] SMCG_OFS_MODE      = 12'h070;
    localparam logic [11:0] SMCG_OFS_FAULT     = 12'h074;

    localparam int SMCG_BIT_PWM   = 20;
    localparam int SMCG_BIT_CONV  = 16;
    localparam int SMCG_RATE_HI   = 9;
    localparam int SMCG_RATE_LO   = 8;
    localparam int SMCG_BIT_HIB   = 6;
    localparam int SMCG_BIT_WDOG  = 3;
    localparam int SMCG_BIT_AUTO  = 27;

    // writable bits of the gating registers; everything else reads zero
    localparam logic [31:0] SMCG_GATE_MASK  = 32'h00110348;
    localparam logic [31:0] SMCG_GATE_RESET = 32'h00000040;
    localparam logic [31:0] SMCG_RUNCFG_MASK = 32'h08000000;

    localparam logic [1:0] SMCG_RATE_500K = 2'h2;
    localparam logic [1:0] SMCG_RATE_250K = 2'h1;
    localparam logic [1:0] SMCG_RATE_125K = 2'h0;

    localparam logic [1:0] SMCG_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SMCG_RESP_SLVERR = 2'h2;

    localparam int SMCG_NUM_UNITS = 4;
    // unit index within the gated unit vector
    localparam int SMCG_U_WDOG = 0;
    localparam int SMCG_U_HIB  = 1;
    localparam int SMCG_U_CONV = 2;
    localparam int SMCG_U_PWM  = 3;

    typedef enum logic [2:0] {
        SMCG_MODE_RUN   = 3'h1,
        SMCG_MODE_SLEEP = 3'h2,
        SMCG_MODE_DEEP  = 3'h4
    } smcg_mode_t;
endpackage

// File: hw/smcg_clock_gate.sv
// smcg_clock_gate: latch-free glitch-safe enable for one unit clock.
// assumes: the unit samples gated_en as a clock enable on the system clock.
module smcg_clock_gate (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic en_req,
    output logic      gated_en
);
    // enable changes only at a clock edge, so the unit never sees a runt cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gated_en <= 1'b0;
        end else begin
            gated_en <= en_req;
        end
    end
endmodule

// File: hw/smcg_top.sv
// smcg_top: run, sleep and deep-sleep clock gating registers with unit enables.
// assumes: AXI4-Lite master of one write and one read at a time; unit accesses
// are reported on unit_acc_* and answered with a fault flag by this block.
// Overview of operation
// R1 - set bit clocks unit, clear disables it
// R2 - access to gated unit faults, except hibernation
// R3 - gating bits reset cleared unless noted
// R4 - separate run, sleep and deep-sleep sets
// R5 - sleep sets apply only with auto gating
// R6 - bits 9:8 select converter sample rate
// R7 - software never programs rate above maximum
// R8 - bit 6 gates hibernation clock
// R9 - bit 3 gates watchdog, faults when clear
// R10 - bit 20 gates pwm, faults when clear
// R11 - bit 16 gates converter 0, faults
// R12 - reserved bits read zero, ignore writes
// R13 - sleep register resets to header value
// R14 - sleep register decoded at offset 0x110
// R15 - software enables needed units before use
// R16 - run register decoded at offset 0x100
// R17 - run set governs without auto; glitch-free
//
// Added by the designer: the AXI4-Lite slave port.
module smcg_top
    import smcg_pkg::*;
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic [31:0]               s_axi_awaddr,
    input  wire logic [2:0]                s_axi_awprot,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [31:0]               s_axi_araddr,
    input  wire logic [2:0]                s_axi_arprot,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    input  wire logic                      sleep_req,
    input  wire logic                      deep_sleep_req,
    input  wire logic                      unit_acc_valid,
    input  wire logic [SMCG_NUM_UNITS-1:0] unit_acc_sel,
    output logic                           unit_acc_fault,
    output logic                           unit_acc_done,
    output logic                           watchdog_clock_gate,
    output logic                           hibernation_clock_gate,
    output logic                           converter_clock_gate,
    output logic                           pwm_clock_gate,
    output logic [1:0]                     converter_sample_rate_limit
);
    logic [31:0]               run_gating_reg;
    logic [31:0]               sleep_gating_reg;
    logic [31:0]               deep_sleep_gating_reg;
    logic [31:0]               run_clock_config_reg;
    logic [31:0]               fault_count_reg;
    smcg_mode_t                mode_reg;
    logic                      aw_held_reg;
    logic                      w_held_reg;
    logic [11:0]               aw_addr_reg;
    logic [31:0]               w_data_reg;
    logic [3:0]                w_strb_reg;
    logic                      wr_fire;
    logic                      wr_hit;
    logic [31:0]               active_set;
    logic [SMCG_NUM_UNITS-1:0] unit_en_req;
    logic [SMCG_NUM_UNITS-1:0] unit_en;
    logic                      auto_gating_select;
    logic [31:0]               rd_word;
    logic                      rd_hit;

    function automatic logic [31:0] smcg_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb,
                                               input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        smcg_merge = (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic smcg_is_reg(input logic [11:0] ofs);
        smcg_is_reg = (ofs == SMCG_OFS_RUN) || (ofs == SMCG_OFS_SLEEP) ||
                      (ofs == SMCG_OFS_DEEP) || (ofs == SMCG_OFS_RUNCFG) ||
                      (ofs == SMCG_OFS_MODE) || (ofs == SMCG_OFS_FAULT);
    endfunction

    // write address and data are taken in either order, then answered together
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr[11:0];
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    assign wr_fire = aw_held_reg && w_held_reg;
    assign wr_hit  = smcg_is_reg(aw_addr_reg);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SMCG_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? SMCG_RESP_OKAY : SMCG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // gating sets; reserved bits are masked off so they stay zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_gating_reg <= SMCG_GATE_RESET; // R3
        end else if (wr_fire && aw_addr_reg == SMCG_OFS_RUN) begin // R16
            run_gating_reg <= smcg_merge(run_gating_reg, w_data_reg, w_strb_reg,
                                         SMCG_GATE_MASK); // R12
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_gating_reg <= SMCG_GATE_RESET; // R13
        end else if (wr_fire && aw_addr_reg == SMCG_OFS_SLEEP) begin // R14
            sleep_gating_reg <= smcg_merge(sleep_gating_reg, w_data_reg, w_strb_reg,
                                           SMCG_GATE_MASK); // R12
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            deep_sleep_gating_reg <= SMCG_GATE_RESET; // R4
        end else if (wr_fire && aw_addr_reg == SMCG_OFS_DEEP) begin
            deep_sleep_gating_reg <= smcg_merge(deep_sleep_gating_reg, w_data_reg,
                                                w_strb_reg, SMCG_GATE_MASK);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_clock_config_reg <= 32'h00000000;
        end else if (wr_fire && aw_addr_reg == SMCG_OFS_RUNCFG) begin
            run_clock_config_reg <= smcg_merge(run_clock_config_reg, w_data_reg,
                                               w_strb_reg, SMCG_RUNCFG_MASK);
        end
    end

    assign auto_gating_select = run_clock_config_reg[SMCG_BIT_AUTO];

    // deep sleep wins over sleep when both are requested
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= SMCG_MODE_RUN;
        end else if (deep_sleep_req) begin
            mode_reg <= SMCG_MODE_DEEP;
        end else if (sleep_req) begin
            mode_reg <= SMCG_MODE_SLEEP;
        end else begin
            mode_reg <= SMCG_MODE_RUN;
        end
    end

    always_comb begin
        active_set = run_gating_reg; // R17
        if (auto_gating_select) begin // R5
            unique case (mode_reg)
                SMCG_MODE_RUN:   active_set = run_gating_reg;
                SMCG_MODE_SLEEP: active_set = sleep_gating_reg; // R4
                SMCG_MODE_DEEP:  active_set = deep_sleep_gating_reg;
                default:         active_set = run_gating_reg;
            endcase
        end
    end

    assign unit_en_req[SMCG_U_WDOG] = active_set[SMCG_BIT_WDOG]; // R9
    assign unit_en_req[SMCG_U_HIB]  = active_set[SMCG_BIT_HIB];  // R8
    assign unit_en_req[SMCG_U_CONV] = active_set[SMCG_BIT_CONV]; // R11
    assign unit_en_req[SMCG_U_PWM]  = active_set[SMCG_BIT_PWM];  // R10

    genvar gi;
    generate
        for (gi = 0; gi < SMCG_NUM_UNITS; gi++) begin : g_gate
            smcg_clock_gate u_gate (
                .aclk     (aclk),
                .aresetn  (aresetn),
                .en_req   (unit_en_req[gi]),
                .gated_en (unit_en[gi])
            ); // R17
        end
    endgenerate

    assign watchdog_clock_gate    = unit_en[SMCG_U_WDOG]; // R1
    assign hibernation_clock_gate = unit_en[SMCG_U_HIB];
    assign converter_clock_gate   = unit_en[SMCG_U_CONV];
    assign pwm_clock_gate         = unit_en[SMCG_U_PWM];

    // rate field only ever limits; a value the part cannot run is not clamped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            converter_sample_rate_limit <= SMCG_RATE_125K;
        end else begin
            converter_sample_rate_limit <= active_set[SMCG_RATE_HI:SMCG_RATE_LO]; // R6
        end
    end

    // hibernation access never faults, even with its clock off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unit_acc_done  <= 1'b0;
            unit_acc_fault <= 1'b0;
        end else begin
            unit_acc_done  <= unit_acc_valid;
            unit_acc_fault <= unit_acc_valid &&
                              |(unit_acc_sel & ~unit_en & ~(4'h1 << SMCG_U_HIB)); // R2
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_count_reg <= 32'h00000000;
        end else if (unit_acc_valid &&
                     |(unit_acc_sel & ~unit_en & ~(4'h1 << SMCG_U_HIB))) begin
            fault_count_reg <= fault_count_reg + 32'h00000001;
        end
    end

    // read side: one outstanding read, data registered
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h00000000;
        unique case (s_axi_araddr[11:0])
            SMCG_OFS_RUN:    rd_word = run_gating_reg;
            SMCG_OFS_SLEEP:  rd_word = sleep_gating_reg;
            SMCG_OFS_DEEP:   rd_word = deep_sleep_gating_reg;
            SMCG_OFS_RUNCFG: rd_word = run_clock_config_reg;
            SMCG_OFS_MODE:   rd_word = {25'h0000000, unit_en, mode_reg};
            SMCG_OFS_FAULT:  rd_word = fault_count_reg;
            default:         rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= SMCG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? SMCG_RESP_OKAY : SMCG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// File: dv/smcg_asserts.sv
// smcg_asserts: unit fault, reset and bus hold properties of smcg_top.
// assumes: bound into smcg_top; one aclk domain, sync active-low reset.
module smcg_asserts
    import smcg_pkg::*;
(
    input wire logic                      aclk,
    input wire logic                      aresetn,
    input wire logic [1:0]                s_axi_bresp,
    input wire logic                      s_axi_bvalid,
    input wire logic                      s_axi_bready,
    input wire logic [31:0]               s_axi_rdata,
    input wire logic                      s_axi_rvalid,
    input wire logic                      s_axi_rready,
    input wire logic                      unit_acc_valid,
    input wire logic [SMCG_NUM_UNITS-1:0] unit_acc_sel,
    input wire logic                      unit_acc_fault,
    input wire logic                      unit_acc_done,
    input wire logic                      watchdog_clock_gate,
    input wire logic                      hibernation_clock_gate,
    input wire logic                      converter_clock_gate,
    input wire logic                      pwm_clock_gate,
    input wire logic [1:0]                converter_sample_rate_limit
);
    logic [3:0] gates;
    assign gates = {pwm_clock_gate, converter_clock_gate, hibernation_clock_gate,
                    watchdog_clock_gate};
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_UNIT_DONE: assert property (unit_acc_valid |=> unit_acc_done)
        else $error("unit access unanswered");
    AST_FAULT_GATED: assert property (unit_acc_valid |=>
        unit_acc_fault == |($past(unit_acc_sel) & ~$past(gates) & 4'hD))
        else $error("fault does not follow gates");
    AST_HIB_NO_FAULT: assert property (unit_acc_valid && unit_acc_sel == 4'h2 |=>
        !unit_acc_fault) else $error("hibernation access faulted");
    AST_WDOG_FAULT: assert property (unit_acc_valid && unit_acc_sel == 4'h1 &&
        !watchdog_clock_gate |=> unit_acc_fault) else $error("watchdog fault missing");
    AST_PWM_FAULT: assert property (unit_acc_valid && unit_acc_sel == 4'h8 &&
        !pwm_clock_gate |=> unit_acc_fault) else $error("pwm fault missing");
    AST_CONV_FAULT: assert property (unit_acc_valid && unit_acc_sel == 4'h4 &&
        !converter_clock_gate |=> unit_acc_fault) else $error("converter fault missing");
    AST_RESET_GATES: assert property ($rose(aresetn) |-> ##[1:3]
        (gates == 4'h2 && converter_sample_rate_limit == 2'h0)) else $error("reset gates");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    cover property (unit_acc_done && unit_acc_fault);
    cover property (s_axi_bvalid && s_axi_bresp == SMCG_RESP_SLVERR);
    cover property ($rose(pwm_clock_gate));
endmodule
bind smcg_top smcg_asserts u_smcg_asserts (.*);

// File: dv/sleep_mode_clock_gating_test.sv
// sleep_mode_clock_gating_test: self-checking bench for smcg_top.
// assumes: package, design and bound checker compiled first.
module sleep_mode_clock_gating_test
    import smcg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [31:0] s_axi_rdata, run_v, slp_v, dp_v, d;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [3:0]  s_axi_wstrb = 4'hF, unit_acc_sel = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, converter_sample_rate_limit;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, unit_acc_valid = 1'b0;
    logic        sleep_req = 1'b0, deep_sleep_req = 1'b0, auto_v;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        unit_acc_fault, unit_acc_done, watchdog_clock_gate, pwm_clock_gate;
    logic        hibernation_clock_gate, converter_clock_gate;
    logic [33:0] exp_q[$];
    logic [1:0]  exp_b[$];
    logic        exp_f[$];
    logic [11:0] a;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          n_faulted = 0;

    smcg_top u_smcg_top (.*);

    always #12.5 aclk = ~aclk;

    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic hang();
        n_fail++;
        $display("unexpected at %0t: bus wait ran out", $time);
        tally_and_finish();
    endtask

    // handshakes judged at the falling edge, so no race with the design's own update
    always @(negedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end
        if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(exp_b.pop_front()));
        if (unit_acc_done) check(34'(unit_acc_fault), 34'(exp_f.pop_front()));
    end

    function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return ((o & ~m) | (n & m)) & SMCG_GATE_MASK;
    endfunction

    function automatic logic [31:0] active();
        if (auto_v && deep_sleep_req) return dp_v;
        if (auto_v && sleep_req) return slp_v;
        return run_v;
    endfunction

    task automatic wr(input logic [11:0] o, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] r);
        logic ha, hw, hb;
        int i;
        exp_b.push_back(r);
        case (o)
            SMCG_OFS_RUN:    run_v = merge(run_v, v, s);
            SMCG_OFS_SLEEP:  slp_v = merge(slp_v, v, s);
            SMCG_OFS_DEEP:   dp_v = merge(dp_v, v, s);
            SMCG_OFS_RUNCFG: if (s[3]) auto_v = v[SMCG_BIT_AUTO];
            default:         ;
        endcase
        @(posedge aclk);
        s_axi_awaddr <= SMCG_SYSCTL_BASE | 32'(o);
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge aclk);
            ha = s_axi_awvalid && s_axi_awready;
            hw = s_axi_wvalid && s_axi_wready;
            hb = s_axi_bvalid;
            @(posedge aclk);
            if (ha) s_axi_awvalid <= 1'b0;
            if (hw) s_axi_wvalid <= 1'b0;
            if (hb) break;
        end
        s_axi_bready <= 1'b0;
        if (i == 50) hang();
    endtask

    task automatic rd(input logic [11:0] o, input logic [1:0] r, input logic [31:0] v);
        logic ha, hr;
        int i;
        exp_q.push_back({r, v});
        @(posedge aclk);
        s_axi_araddr <= SMCG_SYSCTL_BASE | 32'(o);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge aclk);
            ha = s_axi_arvalid && s_axi_arready;
            hr = s_axi_rvalid;
            @(posedge aclk);
            if (ha) s_axi_arvalid <= 1'b0;
            if (hr) break;
        end
        s_axi_rready <= 1'b0;
        if (i == 50) hang();
    endtask

    // let a register or mode change reach the gates, then probe all four units
    task automatic probe();
        logic [31:0] v;
        int k;
        logic f;
        repeat (4) @(posedge aclk);
        // gates settle at the edge; look between edges
        @(negedge aclk);
        v = active();
        check(34'({pwm_clock_gate, converter_clock_gate, hibernation_clock_gate,
                   watchdog_clock_gate, converter_sample_rate_limit}),
              34'({v[20], v[16], v[6], v[3], v[9:8]}));
        @(posedge aclk);
        for (k = 0; k < 4; k++) begin
            unit_acc_valid <= 1'b1;
            unit_acc_sel <= 4'(1 << k);
            f = k != 1 && !v[k == 0 ? 3 : k == 2 ? 16 : k == 3 ? 20 : 6];
            exp_f.push_back(f);
            n_faulted += f;
            @(posedge aclk);
        end
        unit_acc_valid <= 1'b0;
    endtask

    task automatic reset_all();
        run_v = SMCG_GATE_RESET;
        slp_v = SMCG_GATE_RESET;
        dp_v = SMCG_GATE_RESET;
        auto_v = 1'b0;
        n_faulted = 0;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(SMCG_OFS_RUN, SMCG_RESP_OKAY, 32'h00000040);
        rd(SMCG_OFS_SLEEP, SMCG_RESP_OKAY, 32'h00000040);
        rd(SMCG_OFS_DEEP, SMCG_RESP_OKAY, 32'h00000040);
        probe();
    endtask

    initial begin
        void'($urandom(32'h8E4789E8));
        reset_all();
        wr(SMCG_OFS_RUN, 32'hFFFFFEFF, 4'hF, SMCG_RESP_OKAY);
        rd(SMCG_OFS_RUN, SMCG_RESP_OKAY, 32'h00110248);
        probe();
        wr(SMCG_OFS_RUN, 32'h0, 4'h1, SMCG_RESP_OKAY);
        probe();
        repeat (6) begin
            d = $urandom & 32'hFFFFFEFF;
            a = $urandom_range(2) == 0 ? SMCG_OFS_RUN :
                SMCG_OFS_SLEEP + 12'(16 * $urandom_range(1));
            wr(a, d, 4'hF, SMCG_RESP_OKAY);
            rd(a, SMCG_RESP_OKAY, d & SMCG_GATE_MASK);
            probe();
        end
        wr(SMCG_OFS_RUN, 32'h00000008, 4'hF, SMCG_RESP_OKAY);
        wr(SMCG_OFS_SLEEP, 32'h00010140, 4'hF, SMCG_RESP_OKAY);
        wr(SMCG_OFS_DEEP, 32'h00100000, 4'hF, SMCG_RESP_OKAY);
        sleep_req <= 1'b1;
        probe();
        wr(SMCG_OFS_RUNCFG, 32'hFFFFFFFF, 4'hF, SMCG_RESP_OKAY);
        rd(SMCG_OFS_RUNCFG, SMCG_RESP_OKAY, 32'h08000000);
        probe();
        // sleep mode with converter and hibernation enabled
        rd(SMCG_OFS_MODE, SMCG_RESP_OKAY, 32'h00000032);
        deep_sleep_req <= 1'b1;
        probe();
        sleep_req <= 1'b0;
        deep_sleep_req <= 1'b0;
        probe();
        rd(SMCG_OFS_FAULT, SMCG_RESP_OKAY, 32'(n_faulted));
        wr(12'h0FC, 32'h1, 4'hF, SMCG_RESP_SLVERR);
        rd(12'h0FC, SMCG_RESP_SLVERR, 32'h0);
        reset_all();
        // last unit answer lands on the final probe's closing edge and is checked at the next falling edge
        repeat (2) @(posedge aclk);
        check(34'(exp_q.size() + exp_b.size() + exp_f.size()), 34'h0);
        tally_and_finish();
    end
endmodule
